// ---- tps_pkg.sv ----
/*
 * Shared constants and carrier types for the tape port session control
 * block. Assumes a 200 MHz system clock and a 32-bit classic Wishbone
 * register bus with byte addresses.
 */
package tps_pkg;

	// ========================================================================
	// timing
	// ========================================================================
	localparam int unsigned TPS_CLK_HZ = 200_000_000;
	localparam int unsigned TPS_MS_PER_S = 1000;
	localparam int unsigned TPS_DEFAULT_BAUD = 9600;
	localparam int unsigned TPS_MS_CYCLES = TPS_CLK_HZ / TPS_MS_PER_S;
	localparam int unsigned TPS_BIT_CYCLES = TPS_CLK_HZ / TPS_DEFAULT_BAUD;
	// 100 ms entering timer, 2500 ms network acknowledgement time-out
	localparam logic [15:0] TPS_TX_ENTER_MS = 16'h0064;
	localparam logic [15:0] TPS_NET_ACK_TMO_MS = 16'h09C4;
	// serial time-out = base + offset * step
	localparam logic [15:0] TPS_ACK_TMO_BASE_MS = 16'h03E8;
	localparam logic [15:0] TPS_ACK_TMO_STEP_MS = 16'h0064;

	// ========================================================================
	// default operating parameters
	// ========================================================================
	localparam logic [7:0] TPS_DEFAULT_ACK_OFFSET = 8'h01;
	localparam logic [15:0] TPS_DEFAULT_MAX_PAYLOAD = 16'h0100;

	// ========================================================================
	// register map
	// ========================================================================
	localparam logic [7:0] TPS_REG_CTRL = 8'h00;
	localparam logic [7:0] TPS_REG_LOGOUT_DUR = 8'h04;
	localparam logic [7:0] TPS_REG_STATUS = 8'h08;
	localparam logic [7:0] TPS_REG_PARAM = 8'h0C;
	localparam logic [7:0] TPS_REG_BIT_DIV = 8'h10;
	localparam logic [7:0] TPS_REG_ACK_TMO = 8'h14;
	localparam logic [7:0] TPS_REG_NEXUS_CNT = 8'h18;
	localparam int TPS_CTRL_NET_BIT = 0;
	localparam int TPS_CTRL_TMR_BIT = 1;
	localparam int TPS_ST_PORT_LSB = 0;
	localparam int TPS_ST_TX_BIT = 2;
	localparam int TPS_ST_SENSE_BIT = 3;
	localparam int TPS_ST_AER_BIT = 4;
	localparam int TPS_ST_RSTREQ_BIT = 5;
	localparam int TPS_PARAM_ACK_LSB = 16;

	// ========================================================================
	// pins and serial framing
	// ========================================================================
	localparam int TPS_NUM_PINS = 3;
	localparam int TPS_PIN_RX = 0;
	localparam int TPS_PIN_SENSE = 1;
	localparam int TPS_PIN_RST = 2;
	localparam logic [2:0] TPS_PIN_IDLE = 3'h1;
	localparam logic [2:0] TPS_LAST_DATA_BIT = 3'h7;

	// ========================================================================
	// types
	// ========================================================================
	typedef enum logic [1:0] {
		TPS_PORT_INITIAL = 2'b00,
		TPS_PORT_LOGGED_IN = 2'b01,
		TPS_PORT_LOGGED_OUT = 2'b10
	} tps_port_state_type;

	typedef enum logic {
		TPS_TX_ENTERING = 1'b0,
		TPS_TX_ACTIVE = 1'b1
	} tps_tx_state_type;

	typedef enum logic [1:0] {
		TPS_U_IDLE = 2'b00,
		TPS_U_START = 2'b01,
		TPS_U_DATA = 2'b10,
		TPS_U_STOP = 2'b11
	} tps_uart_state_type;

	typedef struct packed {
		logic [15:0] bit_div;
		logic [7:0] ack_offset;
		logic [15:0] max_payload;
	} tps_param_type;

	typedef struct packed {
		logic login_sent;
		logic login_rcvd;
		logic login_aoe;
		logic login_done;
		logic devreset_ack;
		logic logout_rcvd;
		logic logout_ack_sent;
		logic [15:0] logout_dur_ms;
		logic disc_confirm;
		logic disc_received;
		logic tmo_iu;
		logic [15:0] tmo_iu_ms;
		logic frame_start;
	} tps_link_ev_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tps_wb_req_type;

endpackage

// ---- tps_port_ctrl.sv ----
/*
 * Drive-side port session control: port and transmitter state machines,
 * operating parameters, nexus loss events, acknowledgement time-out,
 * serial byte framing and presence sensing, with a Wishbone register file.
 * Assumes link-layer events arrive as one-cycle pulses on clk_i and the
 * sense, reset-request and serial receive pins are asynchronous.
 */
`timescale 1ns/1ps
module tps_port_ctrl
	import tps_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TPS_MS_CYCLES,
	parameter logic [15:0] BIT_CYCLES = 16'(TPS_BIT_CYCLES)
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tps_pkg::tps_wb_req_type wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic serial_rx_i,
	input wire logic automation_sense_i,
	input wire logic automation_reset_req_i,
	output logic serial_tx_o,
	input wire tps_pkg::tps_link_ev_type link_ev_i,
	input wire tps_pkg::tps_param_type neg_param_i,
	input wire logic tx_byte_valid_i,
	input wire logic [7:0] tx_byte_i,
	output logic tx_byte_ready_o,
	output logic rx_byte_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_frame_err_o,
	output logic iu_tx_allowed_o,
	output tps_pkg::tps_port_state_type port_state_o,
	output tps_pkg::tps_param_type param_o,
	output logic [15:0] frame_ack_tmo_o,
	output logic aer_enable_o,
	output logic abort_exchanges_o,
	output logic nexus_loss_o,
	output logic automation_present_o
);
	import tps_pkg::*;

	// ========================================================================
	// state
	// ========================================================================
	typedef struct packed {
		tps_port_state_type port_st;
		tps_tx_state_type tx_st;
		logic net;
		logic tmr_en;
		logic [15:0] impl_dur;
		logic [19:0] ms_cnt;
		logic ms_tick;
		logic [15:0] enter_ms;
		logic [15:0] dur_ms;
		logic logout_pend;
		logic [15:0] logout_dur;
		tps_param_type param;
		logic [15:0] ack_tmo;
		logic [15:0] frame_tmo;
		logic aer;
		logic nexus;
		logic abort;
		logic [15:0] nexus_cnt;
		logic [TPS_NUM_PINS-1:0] s1;
		logic [TPS_NUM_PINS-1:0] s2;
		logic [TPS_NUM_PINS-1:0] s3;
		logic [TPS_NUM_PINS-1:0] f;
		tps_uart_state_type tx_u;
		logic [15:0] tx_cnt;
		logic [2:0] tx_idx;
		logic [7:0] tx_sh;
		logic tx_pin;
		logic tx_rdy;
		tps_uart_state_type rx_u;
		logic [15:0] rx_cnt;
		logic [2:0] rx_idx;
		logic [7:0] rx_sh;
		logic [7:0] rx_byte;
		logic rx_valid;
		logic rx_err;
		logic ack;
		logic [31:0] rdat;
	} tps_state_type;

	localparam tps_param_type PARAM_DEFAULT = '{
		bit_div: BIT_CYCLES,
		ack_offset: TPS_DEFAULT_ACK_OFFSET,
		max_payload: TPS_DEFAULT_MAX_PAYLOAD
	};
	localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);

	// ========================================================================
	// functions
	// ========================================================================
	function automatic logic [15:0] tps_ack_tmo(input tps_param_type p);
		logic [31:0] t;
		t = 32'(TPS_ACK_TMO_STEP_MS) * 32'(p.ack_offset);
		t = t + 32'(TPS_ACK_TMO_BASE_MS);
		return t[15:0];
	endfunction

	function automatic logic tps_bit_end(input logic [15:0] cnt,
		input logic [15:0] div);
		return cnt == div - 16'h0001;
	endfunction

	function automatic logic [31:0] tps_merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[b*8 +: 8] = wdat[b*8 +: 8];
		end
		return r;
	endfunction

	localparam logic [15:0] TMO_DEFAULT = tps_ack_tmo(PARAM_DEFAULT);

	tps_state_type q;
	tps_state_type d;

	// ========================================================================
	// event decode
	// ========================================================================
	logic impl;
	logic rst_rise;
	logic sense_fall;
	logic nexus_ev;
	logic wb_req;
	logic ctrl_wr;
	logic dur_wr;
	logic [31:0] ctrl_rd;
	logic [31:0] status_rd;

	// a disconnect is posted regardless of transmitter state
	assign impl = q.net & (link_ev_i.disc_confirm | link_ev_i.disc_received);
	// edges judged on the agreeing second and third stages only
	assign rst_rise = ~q.f[TPS_PIN_RST] & q.s2[TPS_PIN_RST]
		& q.s3[TPS_PIN_RST];
	assign sense_fall = q.f[TPS_PIN_SENSE] & ~q.s2[TPS_PIN_SENSE]
		& ~q.s3[TPS_PIN_SENSE];
	assign nexus_ev = (link_ev_i.login_sent & link_ev_i.login_aoe)
		| (link_ev_i.login_rcvd & link_ev_i.login_aoe)
		| link_ev_i.devreset_ack
		| (sense_fall & ~q.net)
		| rst_rise
		| (impl & (q.port_st == TPS_PORT_LOGGED_IN));
	assign wb_req = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
	assign ctrl_wr = wb_req & wb_req_i.we & (wb_req_i.adr == TPS_REG_CTRL);
	assign dur_wr = wb_req & wb_req_i.we
		& (wb_req_i.adr == TPS_REG_LOGOUT_DUR);
	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd[TPS_CTRL_NET_BIT] = q.net;
		ctrl_rd[TPS_CTRL_TMR_BIT] = q.tmr_en;
		status_rd = '0;
		status_rd[TPS_ST_PORT_LSB +: 2] = q.port_st;
		status_rd[TPS_ST_TX_BIT] = q.tx_st;
		status_rd[TPS_ST_SENSE_BIT] = q.f[TPS_PIN_SENSE];
		status_rd[TPS_ST_AER_BIT] = q.aer;
		status_rd[TPS_ST_RSTREQ_BIT] = q.f[TPS_PIN_RST];
	end

	// ========================================================================
	// next state
	// ========================================================================
	always_comb
	begin
		d = q;
		d.nexus = nexus_ev;
		d.abort = 1'b0;
		d.rx_valid = 1'b0;
		d.rx_err = 1'b0;
		d.ack = 1'b0;
		d.ms_tick = 1'b0;
		// three-stage pin sampling, a level counts once stages 2 and 3 agree
		d.s1 = {automation_reset_req_i, automation_sense_i, serial_rx_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < TPS_NUM_PINS; i++)
		begin
			if (q.s2[i] == q.s3[i])
				d.f[i] = q.s3[i];
		end
		if (q.ms_cnt == MS_LAST)
		begin
			d.ms_cnt = '0;
			d.ms_tick = 1'b1;
		end
		else
			d.ms_cnt = q.ms_cnt + 20'h00001;
		if (nexus_ev)
			d.nexus_cnt = q.nexus_cnt + 16'h0001;
		if ((link_ev_i.login_sent | link_ev_i.login_rcvd) & link_ev_i.login_aoe)
			d.aer = 1'b1;

		// port state machine
		unique case (q.port_st)
			TPS_PORT_INITIAL:
			begin
				if (link_ev_i.login_done)
				begin
					d.port_st = TPS_PORT_LOGGED_IN;
					d.param = neg_param_i;
				end
			end
			TPS_PORT_LOGGED_IN:
			begin
				if (impl)
				begin
					d.port_st = TPS_PORT_LOGGED_OUT;
					d.dur_ms = q.impl_dur;
					d.logout_pend = 1'b0;
				end
				else if (q.logout_pend & link_ev_i.logout_ack_sent)
				begin
					d.port_st = TPS_PORT_LOGGED_OUT;
					d.dur_ms = q.logout_dur;
					d.logout_pend = 1'b0;
				end
				else if (link_ev_i.logout_rcvd)
				begin
					d.logout_pend = 1'b1;
					d.logout_dur = link_ev_i.logout_dur_ms;
				end
			end
			TPS_PORT_LOGGED_OUT:
			begin
				if (q.dur_ms == '0)
				begin
					d.port_st = TPS_PORT_INITIAL;
					d.param = PARAM_DEFAULT;
				end
				else if (q.ms_tick)
					d.dur_ms = q.dur_ms - 16'h0001;
			end
			default:
				d.port_st = TPS_PORT_INITIAL;
		endcase
		// implicit logout restores the defaults over a login finishing in the same cycle; port_st still moves to logged in
		if (impl)
		begin
			d.abort = 1'b1;
			d.aer = 1'b0;
			d.param = PARAM_DEFAULT;
		end

		// transmitter state machine; entering only follows reset
		unique case (q.tx_st)
			TPS_TX_ENTERING:
			begin
				if (q.net & ~q.tmr_en)
					d.tx_st = TPS_TX_ACTIVE;
				else if (q.enter_ms == TPS_TX_ENTER_MS)
					d.tx_st = TPS_TX_ACTIVE;
				else if (q.ms_tick)
					d.enter_ms = q.enter_ms + 16'h0001;
			end
			TPS_TX_ACTIVE:
				d.tx_st = TPS_TX_ACTIVE;
		endcase

		// acknowledgement time-out
		if (!q.net)
			d.ack_tmo = tps_ack_tmo(d.param);
		else if (link_ev_i.tmo_iu)
			d.ack_tmo = link_ev_i.tmo_iu_ms;
		if (link_ev_i.frame_start)
			d.frame_tmo = q.ack_tmo;

		// serial transmitter, bit time follows the active parameters
		unique case (q.tx_u)
			TPS_U_IDLE:
			begin
				d.tx_pin = 1'b1;
				if (q.tx_rdy & tx_byte_valid_i)
				begin
					d.tx_sh = tx_byte_i;
					d.tx_cnt = '0;
					d.tx_u = TPS_U_START;
					d.tx_pin = 1'b0;
				end
			end
			TPS_U_START:
			begin
				if (tps_bit_end(q.tx_cnt, q.param.bit_div))
				begin
					d.tx_cnt = '0;
					d.tx_idx = '0;
					d.tx_pin = q.tx_sh[0];
					d.tx_u = TPS_U_DATA;
				end
				else
					d.tx_cnt = q.tx_cnt + 16'h0001;
			end
			TPS_U_DATA:
			begin
				if (tps_bit_end(q.tx_cnt, q.param.bit_div))
				begin
					d.tx_cnt = '0;
					d.tx_sh = {1'b0, q.tx_sh[7:1]};
					d.tx_idx = q.tx_idx + 3'h1;
					d.tx_pin = q.tx_sh[1];
					if (q.tx_idx == TPS_LAST_DATA_BIT)
					begin
						d.tx_pin = 1'b1;
						d.tx_u = TPS_U_STOP;
					end
				end
				else
					d.tx_cnt = q.tx_cnt + 16'h0001;
			end
			TPS_U_STOP:
			begin
				if (tps_bit_end(q.tx_cnt, q.param.bit_div))
					d.tx_u = TPS_U_IDLE;
				else
					d.tx_cnt = q.tx_cnt + 16'h0001;
			end
		endcase
		// nothing is taken from the link layer until the transmitter is active
		d.tx_rdy = (d.tx_u == TPS_U_IDLE) & (d.tx_st == TPS_TX_ACTIVE);

		// serial receiver, samples at mid-bit
		unique case (q.rx_u)
			TPS_U_IDLE:
			begin
				d.rx_cnt = '0;
				if (!q.f[TPS_PIN_RX])
					d.rx_u = TPS_U_START;
			end
			TPS_U_START:
			begin
				if (q.rx_cnt == {1'b0, q.param.bit_div[15:1]})
				begin
					d.rx_cnt = '0;
					d.rx_idx = '0;
					d.rx_u = q.f[TPS_PIN_RX] ? TPS_U_IDLE : TPS_U_DATA;
				end
				else
					d.rx_cnt = q.rx_cnt + 16'h0001;
			end
			TPS_U_DATA:
			begin
				if (tps_bit_end(q.rx_cnt, q.param.bit_div))
				begin
					d.rx_cnt = '0;
					d.rx_sh = {q.f[TPS_PIN_RX], q.rx_sh[7:1]};
					d.rx_idx = q.rx_idx + 3'h1;
					if (q.rx_idx == TPS_LAST_DATA_BIT)
						d.rx_u = TPS_U_STOP;
				end
				else
					d.rx_cnt = q.rx_cnt + 16'h0001;
			end
			TPS_U_STOP:
			begin
				if (tps_bit_end(q.rx_cnt, q.param.bit_div))
				begin
					d.rx_u = TPS_U_IDLE;
					d.rx_byte = q.rx_sh;
					d.rx_valid = q.f[TPS_PIN_RX];
					d.rx_err = ~q.f[TPS_PIN_RX];
				end
				else
					d.rx_cnt = q.rx_cnt + 16'h0001;
			end
		endcase

		// register bus; unmapped reads return zero, writes are dropped
		if (wb_req)
		begin
			d.ack = 1'b1;
			d.rdat = '0;
			if (ctrl_wr)
			begin
				d.rdat = tps_merge(ctrl_rd, wb_req_i.dat, wb_req_i.sel);
				d.net = d.rdat[TPS_CTRL_NET_BIT];
				d.tmr_en = d.rdat[TPS_CTRL_TMR_BIT];
				d.ack_tmo = d.net ? TPS_NET_ACK_TMO_MS : tps_ack_tmo(d.param);
				d.rdat = '0;
			end
			else if (dur_wr)
			begin
				// merge parked in rdat, a write still reads back zero
				d.rdat = tps_merge({16'h0000, q.impl_dur},
					wb_req_i.dat, wb_req_i.sel);
				d.impl_dur = d.rdat[15:0];
				d.rdat = '0;
			end
			else if (!wb_req_i.we)
			begin
				unique case (wb_req_i.adr)
					TPS_REG_CTRL: d.rdat = ctrl_rd;
					TPS_REG_LOGOUT_DUR: d.rdat = {16'h0000, q.impl_dur};
					TPS_REG_STATUS: d.rdat = status_rd;
					TPS_REG_PARAM: d.rdat = {8'h00, q.param.ack_offset,
						q.param.max_payload};
					TPS_REG_BIT_DIV: d.rdat = {16'h0000, q.param.bit_div};
					TPS_REG_ACK_TMO: d.rdat = {16'h0000, q.ack_tmo};
					TPS_REG_NEXUS_CNT: d.rdat = {16'h0000, q.nexus_cnt};
					default: d.rdat = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.tmr_en <= 1'b1;
			q.param <= PARAM_DEFAULT;
			q.ack_tmo <= TMO_DEFAULT;
			q.s1 <= TPS_PIN_IDLE;
			q.s2 <= TPS_PIN_IDLE;
			q.s3 <= TPS_PIN_IDLE;
			q.f <= TPS_PIN_IDLE;
			q.tx_pin <= 1'b1;
		end
		else
			q <= d;
	end

	// ========================================================================
	// outputs
	// ========================================================================
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign serial_tx_o = q.tx_pin;
	assign tx_byte_ready_o = q.tx_rdy;
	assign rx_byte_valid_o = q.rx_valid;
	assign rx_byte_o = q.rx_byte;
	assign rx_frame_err_o = q.rx_err;
	assign iu_tx_allowed_o = q.tx_st;
	assign port_state_o = q.port_st;
	assign param_o = q.param;
	assign frame_ack_tmo_o = q.frame_tmo;
	assign aer_enable_o = q.aer;
	assign abort_exchanges_o = q.abort;
	assign nexus_loss_o = q.nexus;
	assign automation_present_o = q.f[TPS_PIN_SENSE];

	// ========================================================================
	// assertions
	// ========================================================================
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// two cycles of slack: tick prescaler plus the state register
	localparam logic [31:0] ENTER_CYC = 32'(TPS_TX_ENTER_MS) * 32'(MS_CYCLES);
	localparam logic [31:0] ENTER_SLACK = 32'h00000002;
	logic [31:0] enter_cyc_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			enter_cyc_q <= '0;
		else if (q.tx_st == TPS_TX_ENTERING)
			enter_cyc_q <= enter_cyc_q + 32'h00000001;
	end

	sequence s_tx_take;
		q.tx_rdy && tx_byte_valid_i;
	endsequence
	sequence s_logout_done;
		q.port_st == TPS_PORT_LOGGED_IN && q.logout_pend && !impl
			&& link_ev_i.logout_ack_sent;
	endsequence

	a_wb_ack_pulse: assert property (q.ack |=> !q.ack)
		else $error("bus ack held longer than one cycle");
	a_default_params: assert property (q.port_st == TPS_PORT_INITIAL |-> q.param == PARAM_DEFAULT)
		else $error("non-default parameters before login");
	a_login_applies: assert property (q.port_st == TPS_PORT_INITIAL && link_ev_i.login_done && !impl |=> q.param == $past(neg_param_i))
		else $error("negotiated parameters not applied");
	a_logout_seq: assert property (s_logout_done |=> q.port_st == TPS_PORT_LOGGED_OUT)
		else $error("no logged out state after logout ack");
	a_impl_logout: assert property (impl && q.port_st == TPS_PORT_LOGGED_IN |=> q.port_st == TPS_PORT_LOGGED_OUT && nexus_loss_o && q.dur_ms == $past(q.impl_dur))
		else $error("implicit logout mishandled");
	a_impl_effects: assert property (impl |=> abort_exchanges_o && !aer_enable_o && q.param == PARAM_DEFAULT)
		else $error("implicit logout effects missing");
	a_logout_expire: assert property (q.port_st == TPS_PORT_LOGGED_OUT && q.dur_ms == '0 |=> q.port_st == TPS_PORT_INITIAL)
		else $error("logout duration expiry ignored");
	a_enter_timer: assert property ($rose(q.tx_st) && !q.net
		|-> enter_cyc_q >= ENTER_CYC && enter_cyc_q <= ENTER_CYC + ENTER_SLACK)
		else $error("entering timer length wrong");
	a_entering_quiet: assert property (q.tx_st == TPS_TX_ENTERING |-> !tx_byte_ready_o && serial_tx_o)
		else $error("transmit while entering");
	a_aoe_nexus: assert property ((link_ev_i.login_sent || link_ev_i.login_rcvd) && link_ev_i.login_aoe |=> nexus_loss_o)
		else $error("login with event enable gave no nexus loss");
	a_devrst_nexus: assert property (link_ev_i.devreset_ack |=> nexus_loss_o
		##1 (!nexus_loss_o || $past(nexus_ev)))
		else $error("device reset ack gave no nexus loss");
	a_sense_nexus: assert property (sense_fall && !q.net |=> nexus_loss_o && !automation_present_o)
		else $error("presence loss gave no nexus loss");
	a_rstreq_nexus: assert property (rst_rise |=> nexus_loss_o)
		else $error("reset request gave no nexus loss");
	a_serial_tmo: assert property (!q.net |-> q.ack_tmo == tps_ack_tmo(q.param))
		else $error("serial time-out stale");
	a_frame_tmo: assert property (link_ev_i.frame_start |=> frame_ack_tmo_o == $past(q.ack_tmo))
		else $error("frame time-out not captured");
	a_net_tmo: assert property (q.net && link_ev_i.tmo_iu && !ctrl_wr |=> q.ack_tmo == $past(link_ev_i.tmo_iu_ms))
		else $error("time-out unit not applied");
	a_start_bit: assert property (s_tx_take |=> !serial_tx_o [*8])
		else $error("start bit missing");
endmodule

// ---- tps_peer.sv ----
/* peer port model: drives our serial receive line with framed bytes
   and its presence on the sense line.
   assumes the bench clock and a fixed bit length in clock cycles */
`timescale 1ns/1ps
module tps_peer #(
	parameter int DIV = 16
)
(
	input wire logic clk_i,
	output logic line_o,
	output logic sense_o
);
	// ==========
	// line idles at stop level between bytes
	initial line_o = 1'b1;
	// present from the start; the block watches this sense line
	initial sense_o = 1'b1;
	// stp low sends a broken stop bit, then the line goes back to idle
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i) line_o <= f[i];
			repeat (DIV - 1) @(posedge clk_i);
		end
		if (!stp)
			@(posedge clk_i) line_o <= 1'b1;
	endtask
	// leaving drops the sense line, a nexus loss at the block while net is off
	task automatic detach;
		@(posedge clk_i) sense_o <= 1'b0;
	endtask
endmodule

// ---- testbench.sv ----
/* self-checking bench for the port session block.
   assumes shortened ms and bit counts and the peer model on receive */
`timescale 1ns/1ps
module testbench;
	import tps_pkg::*;
	// ==========
	localparam tps_param_type DEF = '{16'h0010, 8'h01, 16'h0100};
	localparam tps_param_type NEG = '{16'h000A, 8'h03, 16'h0040};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	tps_wb_req_type wb_req_i = '0;
	tps_link_ev_type link_ev_i = '0;
	tps_param_type neg_param_i = NEG;
	logic automation_reset_req_i = 1'b0;
	logic tx_byte_valid_i = 1'b0;
	logic [7:0] tx_byte_i = 8'h00;
	logic serial_rx_i, wb_ack_o, serial_tx_o, tx_byte_ready_o;
	logic rx_byte_valid_o, iu_tx_allowed_o, aer_enable_o, nexus_loss_o;
	logic abort_exchanges_o, automation_present_o, automation_sense_i;
	logic rx_frame_err_o;
	logic [7:0] rx_byte_o;
	logic [15:0] frame_ack_tmo_o;
	logic [31:0] wb_dat_o, rd;
	tps_port_state_type port_state_o;
	tps_param_type param_o;
	logic [8:0] f = {1'b1, 8'hA5};
	logic [4:0] fl;
	int n_errors = 0;
	int n_tests = 0;
	tps_port_ctrl #(.MS_CYCLES(20), .BIT_CYCLES(16'h0010)) dut_u (.clk_i,
		.rst_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .serial_rx_i,
		.automation_sense_i, .automation_reset_req_i, .serial_tx_o,
		.link_ev_i, .neg_param_i, .tx_byte_valid_i, .tx_byte_i,
		.tx_byte_ready_o, .rx_byte_valid_o, .rx_byte_o, .rx_frame_err_o,
		.iu_tx_allowed_o, .port_state_o, .param_o, .frame_ack_tmo_o,
		.aer_enable_o, .abort_exchanges_o, .nexus_loss_o,
		.automation_present_o);
	tps_peer #(.DIV(16)) peer_u (.clk_i, .line_o(serial_rx_i),
		.sense_o(automation_sense_i));
	assign fl = {rx_frame_err_o, port_state_o == TPS_PORT_INITIAL,
		rx_byte_valid_o, tx_byte_ready_o, nexus_loss_o};
	initial forever #2.5 clk_i = ~clk_i;
	// ==========
	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e,
		input logic [39:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic to(input int k, input int lim);
		if (k > lim)
		begin
			n_errors++;
			final_report();
		end
	endtask
	// ack is sampled at the edge, so data is taken there too
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_req_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do
		begin
			@(posedge clk_i);
			k++;
			to(k, 20);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req_i <= '0;
	endtask
	task automatic wt(input int i, input int lim);
		int k;
		k = 0;
		while (fl[i] !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
			k++;
			to(k, lim);
		end
	endtask
	task automatic pulse(input tps_link_ev_type e);
		@(posedge clk_i);
		link_ev_i <= e;
		@(posedge clk_i);
		link_ev_i <= '0;
		#1;
	endtask
	// ==========
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk("param", DEF, param_o);
		chk("txok", 0, iu_tx_allowed_o);
		wb(1'b1, TPS_REG_CTRL, 32'h0000_0002);
		wb(1'b0, TPS_REG_ACK_TMO, 32'h0);
		chk("acktmo", 16'h044C, rd);
		wb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", 0, rd);
		repeat (1900) @(posedge clk_i);
		#1;
		chk("ready", 0, tx_byte_ready_o);
		wt(1, 200);
		chk("txok", 1, iu_tx_allowed_o);
		@(posedge clk_i);
		tx_byte_valid_i <= 1'b1;
		tx_byte_i <= 8'hA5;
		@(posedge clk_i);
		tx_byte_valid_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		chk("start", 0, serial_tx_o);
		for (int i = 0; i < 9; i++)
		begin
			repeat (16) @(posedge clk_i);
			#1;
			chk("txbit", f[i], serial_tx_o);
		end
		fork
			peer_u.send(8'h3C, 1'b1);
			wt(2, 400);
		join_any
		chk("rxerr", 0, rx_frame_err_o);
		wait fork;
		chk("rxbyte", 8'h3C, rx_byte_o);
		fork
			peer_u.send(8'h5A, 1'b0);
			wt(4, 400);
		join_any
		chk("rxbad", 0, rx_byte_valid_o);
		wait fork;
		pulse('{login_done: 1'b1, default: '0});
		chk("neg", NEG, param_o);
		pulse('{frame_start: 1'b1, default: '0});
		chk("ftmo", 16'h0514, frame_ack_tmo_o);
		pulse('{login_rcvd: 1'b1, login_aoe: 1'b1, default: '0});
		chk("nexus", 1, nexus_loss_o);
		pulse('{devreset_ack: 1'b1, default: '0});
		chk("nexus", 1, nexus_loss_o);
		pulse('{logout_rcvd: 1'b1, logout_dur_ms: 16'h0002, default: '0});
		pulse('{logout_ack_sent: 1'b1, default: '0});
		chk("state", TPS_PORT_LOGGED_OUT, port_state_o);
		wt(3, 100);
		wb(1'b1, TPS_REG_CTRL, 32'h0000_0001);
		wb(1'b0, TPS_REG_ACK_TMO, 32'h0);
		chk("acktmo", TPS_NET_ACK_TMO_MS, rd);
		for (int k = 0; k < 2; k++)
		begin
			wt(3, 100);
			pulse('{login_done: 1'b1, default: '0});
			pulse('{login_sent: 1'b1, login_aoe: 1'b1, default: '0});
			chk("nexus", 1, nexus_loss_o);
			pulse('{disc_confirm: k == 0, disc_received: k == 1,
				default: '0});
			chk("nexus", 1, nexus_loss_o);
			chk("abort", 1, abort_exchanges_o);
			chk("aer", 0, aer_enable_o);
			chk("param", DEF, param_o);
			chk("state", TPS_PORT_LOGGED_OUT, port_state_o);
		end
		pulse('{tmo_iu: 1'b1, tmo_iu_ms: 16'h0BB8, default: '0});
		wb(1'b0, TPS_REG_ACK_TMO, 32'h0);
		chk("acktmo", 16'h0BB8, rd);
		wb(1'b1, TPS_REG_CTRL, 32'h0000_0002);
		chk("present", 1, automation_present_o);
		peer_u.detach();
		wt(0, 20);
		// let the sense pulse pass so the next wait needs a fresh one
		@(posedge clk_i);
		automation_reset_req_i <= 1'b1;
		#1;
		chk("nexus", 0, nexus_loss_o);
		wt(0, 20);
		final_report();
	end
endmodule
